// [logic/tlb_address_translation.sv]
`timescale 1ns/1ps
`include "tlb_defines.svh"

module tlb_address_translation import tlb_pkg::*; #(
  parameter int ENTRIES = `TLB_ENTRIES,
  parameter int IDX_W = 6
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pipeline translation request
  input wire xlat_req_s xreq,
  // Translation answer
  output xlat_rsp_s xrsp
);
  tlb_entry_s entry_reg [ENTRIES];
  logic [IDX_W-1:0] index_reg;
  logic probe_fail_reg;
  logic [19:0] hi_vpage_reg;
  logic [5:0] hi_asid_reg;
  logic [31:0] lo_reg;
  logic [IDX_W-1:0] wired_reg;
  logic [IDX_W-1:0] rand_idx;
  xlat_rsp_s xrsp_reg;

  // Replacement index runs independently of software
  tlb_random #(
    .ENTRIES(ENTRIES),
    .IDX_W(IDX_W)
  ) u_random (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wired(wired_reg),
    .index(rand_idx)
  );

  // Parallel compare against the pipeline address and the probe key
  logic [ENTRIES-1:0] xl_match;
  logic [ENTRIES-1:0] pr_match;
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_cmp
      assign xl_match[g] = (entry_reg[g].vpage == xreq.vaddr[`PAGE_MSB:`PAGE_LSB]) &&
        (entry_reg[g].global_map || entry_reg[g].asid == hi_asid_reg);
      assign pr_match[g] = (entry_reg[g].vpage == hi_vpage_reg) &&
        (entry_reg[g].global_map || entry_reg[g].asid == hi_asid_reg);
    end
  endgenerate

  // Lowest matching entry wins; software should keep entries unique
  tlb_entry_s hit_entry;
  logic xl_any;
  logic [IDX_W-1:0] pr_idx;
  logic pr_any;
  always_comb begin
    hit_entry = '0;
    xl_any = 1'b0;
    pr_idx = '0;
    pr_any = 1'b0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (xl_match[i]) begin
        hit_entry = entry_reg[i];
        xl_any = 1'b1;
      end
      if (pr_match[i]) begin
        pr_idx = IDX_W'(i);
        pr_any = 1'b1;
      end
    end
  end

  // Segment decode; kernel-only fixed segments skip the buffer
  logic [2:0] seg;
  logic unmapped;
  assign seg = xreq.vaddr[31:29];
  assign unmapped = (seg == `SEG_CACHED_UNMAPPED) || (seg == `SEG_UNCACHED_UNMAPPED);

  // Translation result, registered one cycle after the request
  xlat_rsp_s rsp_next;
  always_comb begin
    rsp_next = '0;
    rsp_next.vector = `VEC_GENERAL;
    if (xreq.req) begin
      if (unmapped) begin
        rsp_next.hit = 1'b1;
        rsp_next.paddr = {3'h0, xreq.vaddr[28:0]};
        rsp_next.uncached = (seg == `SEG_UNCACHED_UNMAPPED);
        rsp_next.store_ok = xreq.store;
      end else if (!xl_any) begin
        rsp_next.fault = 1'b1;
        rsp_next.fault_kind = XLAT_MISS;
        rsp_next.vector = xreq.user_mode ? `VEC_USER_MISS : `VEC_GENERAL;
      end else if (!hit_entry.valid) begin
        rsp_next.fault = 1'b1;
        rsp_next.fault_kind = XLAT_INVALID;
      end else if (xreq.store && !hit_entry.dirty) begin
        rsp_next.fault = 1'b1;
        rsp_next.fault_kind = XLAT_MODIFIED;
      end else begin
        rsp_next.hit = 1'b1;
        rsp_next.paddr = {hit_entry.ppage, xreq.vaddr[`PAGE_LSB-1:0]};
        rsp_next.uncached = hit_entry.noncache;
        rsp_next.store_ok = xreq.store;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      xrsp_reg <= '0;
    end else begin
      xrsp_reg <= rsp_next;
    end
  end

  assign xrsp = xrsp_reg;

  // APB decode; answers in the access phase with no wait states
  logic wr_en;
  logic rd_en;
  logic mapped;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite; // Setup cycle of a read
  assign mapped = (paddr == `OFF_INDEX) || (paddr == `OFF_RANDOM) ||
    (paddr == `OFF_ENTRY_HI) || (paddr == `OFF_ENTRY_LO) || (paddr == `OFF_CMD) ||
    (paddr == `OFF_PROBE) || (paddr == `OFF_WIRED);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Staging registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hi_vpage_reg <= '0;
      hi_asid_reg <= '0;
      lo_reg <= '0;
      wired_reg <= IDX_W'(`TLB_WIRED);
    end else if (wr_en && paddr == `OFF_ENTRY_HI) begin
      hi_vpage_reg <= pwdata[31:12];
      hi_asid_reg <= pwdata[11:6];
    end else if (wr_en && paddr == `OFF_ENTRY_LO) begin
      lo_reg <= pwdata;
    end else if (wr_en && paddr == `OFF_WIRED) begin
      wired_reg <= pwdata[IDX_W-1:0];
    end else if (wr_en && paddr == `OFF_CMD && pwdata[1:0] == `CMD_READ) begin
      hi_vpage_reg <= entry_reg[index_reg].vpage;
      hi_asid_reg <= entry_reg[index_reg].asid;
      lo_reg <= {entry_reg[index_reg].ppage, entry_reg[index_reg].noncache,
        entry_reg[index_reg].dirty, entry_reg[index_reg].valid,
        entry_reg[index_reg].global_map, 8'h00};
    end
  end

  // Index register; a probe write looks up hi and records the result
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      index_reg <= '0;
      probe_fail_reg <= 1'b0;
    end else if (wr_en && paddr == `OFF_INDEX) begin
      index_reg <= pwdata[IDX_W-1:0];
    end else if (wr_en && paddr == `OFF_PROBE) begin
      index_reg <= pr_idx;
      probe_fail_reg <= !pr_any;
    end
  end

  // Entry store; random writes use the free-running index
  tlb_entry_s new_entry;
  logic [IDX_W-1:0] wr_idx;
  logic ent_we;
  assign new_entry = '{vpage: hi_vpage_reg, asid: hi_asid_reg, ppage: lo_reg[31:12],
    noncache: lo_reg[`LO_NONCACHE], dirty: lo_reg[`LO_DIRTY],
    valid: lo_reg[`LO_VALID], global_map: lo_reg[`LO_GLOBAL]};
  assign ent_we = wr_en && paddr == `OFF_CMD &&
    (pwdata[1:0] == `CMD_WRITE_INDEX || pwdata[1:0] == `CMD_WRITE_RANDOM);
  assign wr_idx = (pwdata[1:0] == `CMD_WRITE_RANDOM) ? rand_idx : index_reg;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < ENTRIES; i++) begin
        entry_reg[i] <= '0;
      end
    end else if (ent_we) begin
      entry_reg[wr_idx] <= new_entry;
    end
  end

  // Read data mux, sampled in the setup cycle
  logic [31:0] rd_mux;
  logic [31:0] prdata_reg;
  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      `OFF_INDEX: rd_mux = {probe_fail_reg, 23'h0, 2'h0, index_reg};
      `OFF_RANDOM: rd_mux = {26'h0, rand_idx};
      `OFF_ENTRY_HI: rd_mux = {hi_vpage_reg, hi_asid_reg, 6'h00};
      `OFF_ENTRY_LO: rd_mux = lo_reg;
      `OFF_WIRED: rd_mux = {26'h0, wired_reg};
      default: rd_mux = '0;
    endcase
  end

  // Flopped read data; cleared after the access edge so it stands one cycle only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prdata_reg <= '0;
    end else if (rd_en) begin
      prdata_reg <= rd_mux;
    end else begin
      prdata_reg <= '0;
    end
  end

  assign prdata = prdata_reg;
endmodule : tlb_address_translation

// [logic/tlb_defines.svh]
`ifndef TLB_DEFINES_SVH
`define TLB_DEFINES_SVH

// Register byte offsets
`define OFF_INDEX 12'h000
`define OFF_RANDOM 12'h004
`define OFF_ENTRY_HI 12'h008
`define OFF_ENTRY_LO 12'h00c
`define OFF_CMD 12'h010
`define OFF_PROBE 12'h014
`define OFF_WIRED 12'h018

// Address split
`define PAGE_MSB 31
`define PAGE_LSB 12
`define ASID_W 6

// Entry-low field positions
`define LO_NONCACHE 11
`define LO_DIRTY 10
`define LO_VALID 9
`define LO_GLOBAL 8

// Command encodings written to the command register
`define CMD_READ 2'h1
`define CMD_WRITE_INDEX 2'h2
`define CMD_WRITE_RANDOM 2'h3

// Segment bases, upper three address bits
`define SEG_CACHED_UNMAPPED 3'h4
`define SEG_UNCACHED_UNMAPPED 3'h5

// Reset values and counts
`define TLB_ENTRIES 64
`define TLB_WIRED 8
`define PROBE_FAIL_BIT 31

// Exception entry points
`define VEC_USER_MISS 32'h8000_0000
`define VEC_GENERAL 32'h8000_0080

`endif

// [logic/tlb_pkg.sv]
package tlb_pkg;
  typedef struct packed {
    logic [19:0] vpage;
    logic [5:0] asid;
    logic [19:0] ppage;
    logic noncache;
    logic dirty;
    logic valid;
    logic global_map;
  } tlb_entry_s;

  typedef enum logic [1:0] {
    XLAT_NONE,
    XLAT_MISS,
    XLAT_INVALID,
    XLAT_MODIFIED
  } xlat_fault_e;

  typedef struct packed {
    logic req;
    logic store;
    logic user_mode;
    logic [31:0] vaddr;
  } xlat_req_s;

  typedef struct packed {
    logic hit;
    logic [31:0] paddr;
    logic uncached;
    logic fault;
    xlat_fault_e fault_kind;
    logic [31:0] vector;
    logic store_ok;
  } xlat_rsp_s;
endpackage : tlb_pkg

// [logic/tlb_random.sv]
`timescale 1ns/1ps
`include "tlb_defines.svh"

// Free-running replacement index, wrapping from top down to the wired floor
module tlb_random import tlb_pkg::*; #(
  parameter int ENTRIES = `TLB_ENTRIES,
  parameter int IDX_W = 6
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Lowest index allowed
  input wire logic [IDX_W-1:0] wired,
  // Current index
  output logic [IDX_W-1:0] index
);
  logic [IDX_W-1:0] index_reg;
  logic [IDX_W-1:0] index_next;

  // Counts down each cycle; never goes below wired
  always_comb begin
    if (index_reg <= wired) begin
      index_next = IDX_W'(ENTRIES - 1);
    end else begin
      index_next = index_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      index_reg <= IDX_W'(ENTRIES - 1);
    end else begin
      index_reg <= index_next;
    end
  end

  assign index = index_reg;
endmodule : tlb_random

// [verification/pipe_req_model.sv]
`timescale 1ns/1ps

module pipe_req_model import tlb_pkg::*; (
  // Clock
  input wire logic ref_clk,
  // Reference to issue
  input wire logic go,
  input wire logic store,
  input wire logic user_mode,
  input wire logic [31:0] vaddr,
  // Request into the translator
  output xlat_req_s xreq
);
  // Address stage; idle cycles show an inverted address so nothing stale matches
  always_ff @(posedge ref_clk) begin
    xreq.req <= go;
    xreq.store <= go & store;
    xreq.user_mode <= user_mode;
    xreq.vaddr <= go ? vaddr : ~vaddr;
  end
endmodule : pipe_req_model

// [verification/tlb_address_translation_checker.sv]
`timescale 1ns/1ps
`include "tlb_defines.svh"

module tlb_address_translation_checker import tlb_pkg::*; #(
  parameter int ENTRIES = 64,
  parameter int IDX_W = 6
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Translation side
  input wire xlat_req_s xreq,
  input wire xlat_rsp_s xrsp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Fixed kernel segments skip the lookup
  wire seg = xreq.req && (xreq.vaddr[31:29] inside {3'h4, 3'h5});
  wire acc = psel && penable;

  chk_seg_nofault: assert property (seg |=> !xrsp.fault
    && xrsp.paddr == ($past(xreq.vaddr) & 32'h1fff_ffff)) else $error("segment access faulted");
  chk_seg_uncached: assert property (seg && xreq.vaddr[29] |=> xrsp.uncached)
    else $error("uncached segment was cached");
  chk_miss_vector: assert property (xrsp.fault && xrsp.fault_kind == XLAT_MISS
    |-> xrsp.vector == ($past(xreq.user_mode) ? `VEC_USER_MISS : `VEC_GENERAL))
    else $error("miss used wrong vector");
  chk_modified_store: assert property (xrsp.fault && xrsp.fault_kind == XLAT_MODIFIED
    |-> $past(xreq.store) && !xrsp.store_ok) else $error("modified fault wrong");
  chk_idle_quiet: assert property (!xreq.req |=> !xrsp.hit && !xrsp.fault)
    else $error("answer without request");
  chk_fault_nohit: assert property (xrsp.fault |-> !xrsp.hit)
    else $error("fault and hit together");
  chk_random_floor: assert property (acc && !pwrite && paddr == `OFF_RANDOM
    |-> prdata[5:0] >= `TLB_WIRED) else $error("random index in wired range");
  chk_unmapped_err: assert property (acc && paddr > `OFF_WIRED |-> pready && pslverr)
    else $error("unmapped access not refused");
endmodule : tlb_address_translation_checker

bind tlb_address_translation tlb_address_translation_checker #(
  .ENTRIES(ENTRIES),
  .IDX_W(IDX_W)
) chk_i (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .xreq(xreq),
  .xrsp(xrsp)
);

// [verification/tlb_address_translation_tb.sv]
`timescale 1ns/1ps
`include "tlb_defines.svh"

module tlb_address_translation_tb import tlb_pkg::*;;
  logic ref_clk, resetn, psel, penable, pwrite, go, store, user_mode, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, vaddr, rd, prdata;
  logic pready, pslverr;
  xlat_req_s xreq;
  xlat_rsp_s xrsp;
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  tlb_address_translation DUT (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xreq(xreq), .xrsp(xrsp));
  pipe_req_model pipe (.ref_clk(ref_clk), .go(go), .store(store), .user_mode(user_mode),
    .vaddr(vaddr), .xreq(xreq));

  // 200 MHz clock
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // One APB transfer; wait states are honoured, not assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic put(input logic [19:0] vp, input logic [31:0] lo, input logic [5:0] idx,
      input logic [1:0] cmd);
    apb(1, `OFF_ENTRY_HI, {vp, 12'h0});
    apb(1, `OFF_ENTRY_LO, lo);
    apb(1, `OFF_INDEX, {26'h0, idx});
    apb(1, `OFF_CMD, {30'h0, cmd});
  endtask : put

  // Answer lands one cycle after the request is taken
  task automatic xl(input logic st, input logic us, input logic [31:0] va);
    @(posedge ref_clk);
    go <= 1;
    store <= st;
    user_mode <= us;
    vaddr <= va;
    @(posedge ref_clk);
    go <= 0;
    @(posedge ref_clk);
    #1;
  endtask : xl

  task automatic fault(string nm, xlat_fault_e k);
    check(nm, {29'h0, k != XLAT_NONE, k}, {29'h0, xrsp.fault, xrsp.fault_kind});
  endtask : fault

  task automatic probe(input logic [19:0] vp);
    apb(1, `OFF_ENTRY_HI, {vp, 12'h0});
    apb(1, `OFF_PROBE, 32'h0);
    apb(0, `OFF_INDEX, 32'h0);
  endtask : probe

  task automatic t_regs;
    logic [31:0] first;
    apb(0, `OFF_WIRED, 32'h0);
    check("wired_reset", 32'h8, rd);
    apb(0, `OFF_RANDOM, 32'h0);
    first = rd;
    check("random_floor", 32'h1, 32'(rd[5:0] >= 6'h8));
    apb(0, `OFF_RANDOM, 32'h0);
    check("random_moves", 32'h1, 32'(rd !== first));
    apb(1, 12'h01c, 32'h0);
    check("unmapped_err", 32'h1, 32'(err));
    $display("test regs done");
  endtask : t_regs

  task automatic t_miss;
    xl(0, 1, 32'h0040_0abc);
    fault("user_miss", XLAT_MISS);
    check("user_vector", `VEC_USER_MISS, xrsp.vector);
    xl(0, 0, 32'hc000_0000);
    check("kernel_vector", `VEC_GENERAL, xrsp.vector);
    $display("test miss done");
  endtask : t_miss

  task automatic t_hit;
    put(20'h00400, {20'h12345, 4'h7, 8'h0}, 6'd8, `CMD_WRITE_INDEX);
    xl(0, 1, 32'h0040_0abc);
    fault("refill_retry", XLAT_NONE);
    check("hit_flag", 32'h1, 32'(xrsp.hit));
    check("hit_paddr", 32'h1234_5abc, xrsp.paddr);
    put(20'h00401, {20'h00abc, 4'h1, 8'h0}, 6'd63, `CMD_WRITE_INDEX);
    xl(0, 0, 32'h0040_1000);
    fault("invalid_entry", XLAT_INVALID);
    put(20'h00402, {20'h00def, 4'hb, 8'h0}, 6'd20, `CMD_WRITE_INDEX);
    xl(0, 0, 32'h0040_2010);
    check("uncached_hit", 32'h00de_f010, xrsp.paddr);
    check("uncached_flag", 32'h1, 32'(xrsp.uncached));
    xl(1, 0, 32'h0040_2010);
    fault("store_protect", XLAT_MODIFIED);
    check("store_blocked", 32'h0, 32'(xrsp.store_ok));
    $display("test hit done");
  endtask : t_hit

  task automatic t_probe;
    apb(1, `OFF_INDEX, 32'h0000_0008);
    apb(1, `OFF_CMD, {30'h0, `CMD_READ});
    apb(0, `OFF_ENTRY_LO, 32'h0);
    check("read_back_lo", 32'h1234_5700, rd);
    apb(0, `OFF_ENTRY_HI, 32'h0);
    check("read_back_hi", 32'h0040_0000, rd);
    probe(20'h00402);
    check("probe_found", 32'd20, rd & 32'h8000_003f);
    probe(20'h00401);
    check("probe_top", 32'd63, rd & 32'h8000_003f);
    probe(20'h00777);
    check("probe_fail", 32'h1, 32'(rd[31]));
    check("probe_quiet", 32'h0, 32'(xrsp.fault));
    $display("test probe done");
  endtask : t_probe

  task automatic t_seg;
    xl(1, 0, 32'h8000_1000);
    fault("cached_seg", XLAT_NONE);
    check("cached_seg_pa", 32'h0000_1000, xrsp.paddr);
    check("seg_store_ok", 32'h1, 32'(xrsp.store_ok));
    xl(0, 0, 32'ha000_2000);
    check("uncached_seg", 32'h1, 32'(xrsp.uncached));
    check("uncached_seg_pa", 32'h0000_2000, xrsp.paddr);
    put(20'h00500, {20'h00111, 4'h3, 8'h0}, 6'd0, `CMD_WRITE_RANDOM);
    probe(20'h00500);
    check("random_slot", 32'h1, 32'(rd[31] == 1'b0 && rd[5:0] >= 6'h8));
    $display("test segments and random done");
  endtask : t_seg

  task automatic final_report;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // Hang guard, far above the roughly 140 cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("mismatch run_length expected done seen hang");
      final_report;
    end
  end

  // Main sequence
  initial begin
    resetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    go = 0;
    store = 0;
    user_mode = 0;
    vaddr = 0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1;
    t_regs;
    t_miss;
    t_hit;
    t_probe;
    t_seg;
    final_report;
  end
endmodule : tlb_address_translation_tb
